/* File: cmpd_pkg.sv */
package cmpd_pkg;

    localparam int CFG_W = 128;

    localparam int POST_A_LSB = 96;
    localparam int POST_B_LSB = 100;
    localparam int POST_C0_LSB = 104;
    localparam int POST_D0_LSB = 108;
    localparam int PATH_C_DIVIDE_CODE_SET0_LSB = 112;
    localparam int PATH_D_DIVIDE_CODE_SET0_LSB = 116;
    localparam int POST_W = 4;

    localparam int MUX_A_LSB = 22;
    localparam int MUX_B_LSB = 46;
    localparam int MUX_C0_LSB = 70;
    localparam int MUX_D0_LSB = 94;
    localparam int PATH_C_SOURCE_SEL_SET0_LSB = 124;
    localparam int PATH_D_SOURCE_SEL_SET0_LSB = 126;
    localparam int MUX_W = 2;

    localparam int LF_1_BIT = 20;
    localparam int LF_2_BIT = 44;
    localparam int LF_3S0_BIT = 68;
    localparam int LF_3S1_BIT = 92;
    localparam int CP_1_BIT = 19;
    localparam int CP_2_BIT = 43;
    localparam int CP_3S0_BIT = 67;
    localparam int CP_3S1_BIT = 91;

    localparam int DIV_W = 6;
    localparam int NPATH = 4;

    localparam int LF_SHORT_US = 7;
    localparam int LF_LONG_US = 20;
    localparam int CP_LOW_UA = 2;
    localparam int CP_HIGH_UA = 10;

    typedef logic [MUX_W-1:0] cmpd_src_t;
    localparam cmpd_src_t SRC_REF = 2'h0;
    localparam cmpd_src_t SRC_PLL1 = 2'h1;
    localparam cmpd_src_t SRC_PLL2 = 2'h2;
    localparam cmpd_src_t SRC_PLL3 = 2'h3;

    localparam logic [POST_W-1:0] CODE_MAX = 4'hf;

    typedef enum logic [1:0] {
        CMPD_RUN  = 2'h1,
        CMPD_SWAP = 2'h2
    } cmpd_state_e;

    localparam logic [DIV_W-1:0] DIV_ONE = 6'h01;

    function automatic logic [DIV_W-1:0] cmpd_ratio(
        input logic [POST_W-1:0] code
    );
        logic [DIV_W-1:0] r;
        r = DIV_ONE;
        case (code)
            4'h0: r = 6'h01;
            4'h1: r = 6'h02;
            4'h2: r = 6'h03;
            4'h3: r = 6'h04;
            4'h4: r = 6'h05;
            4'h5: r = 6'h06;
            4'h6: r = 6'h08;
            4'h7: r = 6'h09;
            4'h8: r = 6'h0a;
            4'h9: r = 6'h0c;
            4'ha: r = 6'h0f;
            4'hb: r = 6'h10;
            4'hc: r = 6'h12;
            4'hd: r = 6'h14;
            4'he: r = 6'h19;
            4'hf: r = 6'h32;
            default: r = DIV_ONE;
        endcase
        return r;
    endfunction

endpackage

/* File: cmpd_divider.sv */
`timescale 1ns/1ps
`default_nettype none
module cmpd_divider (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic [3:0]                 src_tick,
    input  wire cmpd_pkg::cmpd_src_t        src_sel,
    input  wire logic [cmpd_pkg::DIV_W-1:0] ratio,
    output logic                            out_clk_q
);
    import cmpd_pkg::*;

    logic [DIV_W-1:0] cnt_q;
    logic             tick;

    assign tick = src_tick[src_sel];

    // A new ratio or source takes effect at once; the count is not
    // realigned, so a change mid-period can shorten that period.
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q     <= '0;
            out_clk_q <= 1'b0;
        end else if (tick) begin
            if (cnt_q + DIV_ONE >= ratio) begin
                cnt_q     <= '0;
                out_clk_q <= ~out_clk_q;
            end else begin
                cnt_q <= cnt_q + DIV_ONE;
            end
        end
    end

    // Without a tick from its source the output must hold its level.
    a_div_hold: assert property (@(posedge clk) disable iff (rst)
        !tick |=> $stable(out_clk_q))
        else $error("output moved without a source tick");

endmodule // cmpd_divider
`default_nettype wire

/* File: cmpd_clock_config.sv */
`timescale 1ns/1ps
`default_nettype none
module cmpd_clock_config (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic [cmpd_pkg::CFG_W-1:0] cfg,
    input  wire logic                       cd_set_select,
    input  wire logic [3:0]                 src_tick,
    output logic [3:0]                      out_clk,
    output cmpd_pkg::cmpd_src_t             src_sel_a_q,
    output cmpd_pkg::cmpd_src_t             src_sel_b_q,
    output cmpd_pkg::cmpd_src_t             src_sel_c_q,
    output cmpd_pkg::cmpd_src_t             src_sel_d_q,
    output logic [cmpd_pkg::DIV_W-1:0]      ratio_a_q,
    output logic [cmpd_pkg::DIV_W-1:0]      ratio_b_q,
    output logic [cmpd_pkg::DIV_W-1:0]      ratio_c_q,
    output logic [cmpd_pkg::DIV_W-1:0]      ratio_d_q,
    output logic                            pll1_filter_long_q,
    output logic                            pll2_filter_long_q,
    output logic                            pll3_filter_long_q,
    output logic                            pll1_pump_high_q,
    output logic                            pll2_pump_high_q,
    output logic                            pll3_pump_high_q,
    output logic                            set_active_q
);
    import cmpd_pkg::*;

    logic              sel_m_q;
    logic              sel_s_q;
    cmpd_state_e       state_q;
    cmpd_src_t         src_d [NPATH];
    logic [POST_W-1:0] code_d [NPATH];
    logic [DIV_W-1:0]  ratio_q [NPATH];
    cmpd_src_t         src_q [NPATH];

    // The select pin is asynchronous to clk.
    always_ff @(posedge clk) begin
        if (rst) begin
            sel_m_q <= 1'b0;
            sel_s_q <= 1'b0;
        end else begin
            sel_m_q <= cd_set_select;
            sel_s_q <= sel_m_q;
        end
    end

    // One flop holds the active set so C, D and PLL three never disagree.
    always_ff @(posedge clk) begin
        if (rst) begin
            set_active_q <= 1'b0;
            state_q      <= CMPD_RUN;
        end else begin
            case (state_q)
                CMPD_RUN: begin
                    if (sel_s_q != set_active_q) begin
                        state_q <= CMPD_SWAP;
                    end
                end
                CMPD_SWAP: begin
                    set_active_q <= sel_s_q;
                    state_q      <= CMPD_RUN;
                end
                default: state_q <= CMPD_RUN;
            endcase
        end
    end

    always_comb begin
        code_d[0] = cfg[POST_A_LSB +: POST_W];
        code_d[1] = cfg[POST_B_LSB +: POST_W];
        code_d[2] = set_active_q ? cfg[PATH_C_DIVIDE_CODE_SET0_LSB +: POST_W]
                                 : cfg[POST_C0_LSB +: POST_W];
        code_d[3] = set_active_q ? cfg[PATH_D_DIVIDE_CODE_SET0_LSB +: POST_W]
                                 : cfg[POST_D0_LSB +: POST_W];
        src_d[0]  = cfg[MUX_A_LSB +: MUX_W];
        src_d[1]  = cfg[MUX_B_LSB +: MUX_W];
        src_d[2]  = set_active_q ? cfg[PATH_C_SOURCE_SEL_SET0_LSB +: MUX_W]
                                 : cfg[MUX_C0_LSB +: MUX_W];
        src_d[3]  = set_active_q ? cfg[PATH_D_SOURCE_SEL_SET0_LSB +: MUX_W]
                                 : cfg[MUX_D0_LSB +: MUX_W];
    end

    // Fields are applied without any glitch guard, on purpose.
    genvar gi;
    generate
        for (gi = 0; gi < NPATH; gi++) begin : g_path
            always_ff @(posedge clk) begin
                if (rst) begin
                    ratio_q[gi] <= DIV_ONE;
                    src_q[gi]   <= SRC_REF;
                end else begin
                    ratio_q[gi] <= cmpd_ratio(code_d[gi]);
                    src_q[gi]   <= src_d[gi];
                end
            end
            cmpd_divider u_div (
                .clk       (clk),
                .rst       (rst),
                .src_tick  (src_tick),
                .src_sel   (src_q[gi]),
                .ratio     (ratio_q[gi]),
                .out_clk_q (out_clk[gi])
            );
        end
    endgenerate

    assign src_sel_a_q = src_q[0];
    assign src_sel_b_q = src_q[1];
    assign src_sel_c_q = src_q[2];
    assign src_sel_d_q = src_q[3];
    assign ratio_a_q   = ratio_q[0];
    assign ratio_b_q   = ratio_q[1];
    assign ratio_c_q   = ratio_q[2];
    assign ratio_d_q   = ratio_q[3];

    always_ff @(posedge clk) begin
        if (rst) begin
            pll1_filter_long_q <= 1'b0;
            pll2_filter_long_q <= 1'b0;
            pll3_filter_long_q <= 1'b0;
            pll1_pump_high_q   <= 1'b0;
            pll2_pump_high_q   <= 1'b0;
            pll3_pump_high_q   <= 1'b0;
        end else begin
            pll1_filter_long_q <= cfg[LF_1_BIT];
            pll2_filter_long_q <= cfg[LF_2_BIT];
            pll3_filter_long_q <= set_active_q ? cfg[LF_3S1_BIT]
                                               : cfg[LF_3S0_BIT];
            pll1_pump_high_q   <= cfg[CP_1_BIT];
            pll2_pump_high_q   <= cfg[CP_2_BIT];
            pll3_pump_high_q   <= set_active_q ? cfg[CP_3S1_BIT]
                                               : cfg[CP_3S0_BIT];
        end
    end

    // Each check except a_set_follow looks at rst in the cycle before, so the first cycle after
    // a reset is skipped: its outputs still hold the reset values.
    a_ratio_a_map: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) |->
        ratio_a_q == cmpd_ratio($past(cfg[POST_A_LSB +: POST_W])))
        else $error("path A ratio mismatch");
    a_ratio_b_map: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) |->
        ratio_b_q == cmpd_ratio($past(cfg[POST_B_LSB +: POST_W])))
        else $error("path B ratio mismatch");
    a_ratio_top_code: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) && $past(cfg[POST_B_LSB +: POST_W]) == CODE_MAX |->
        ratio_b_q == 6'h32)
        else $error("code 15 not divide by 50");
    a_path_c_div: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) && $past(set_active_q) |->
        ratio_c_q == cmpd_ratio($past(cfg[PATH_C_DIVIDE_CODE_SET0_LSB +: POST_W])))
        else $error("path C set1 ratio wrong");
    a_path_c_low: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) && !$past(set_active_q) |->
        ratio_c_q == cmpd_ratio($past(cfg[POST_C0_LSB +: POST_W])))
        else $error("path C set0 ratio wrong");
    a_path_d_div: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) && !$past(set_active_q) |->
        ratio_d_q == cmpd_ratio($past(cfg[POST_D0_LSB +: POST_W])))
        else $error("path D set0 ratio wrong");
    a_path_d_high: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) && $past(set_active_q) |->
        ratio_d_q == cmpd_ratio($past(cfg[PATH_D_DIVIDE_CODE_SET0_LSB +: POST_W])))
        else $error("path D set1 ratio wrong");
    a_src_a_b: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) |->
        src_sel_a_q == $past(cfg[MUX_A_LSB +: MUX_W]) &&
        src_sel_b_q == $past(cfg[MUX_B_LSB +: MUX_W]))
        else $error("path A or B source wrong");
    a_src_c_d: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) && $past(set_active_q) |->
        src_sel_c_q == $past(cfg[PATH_C_SOURCE_SEL_SET0_LSB +: MUX_W]) &&
        src_sel_d_q == $past(cfg[PATH_D_SOURCE_SEL_SET0_LSB +: MUX_W]))
        else $error("path C or D set1 source wrong");
    a_src_low: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) && !$past(set_active_q) |->
        src_sel_c_q == $past(cfg[MUX_C0_LSB +: MUX_W]) &&
        src_sel_d_q == $past(cfg[MUX_D0_LSB +: MUX_W]))
        else $error("path C or D set0 source wrong");
    a_pll3_tuning: assert property (@(posedge clk)
        disable iff (rst) !$past(rst) && !$past(set_active_q) |->
        pll3_filter_long_q == $past(cfg[LF_3S0_BIT]) &&
        pll3_pump_high_q == $past(cfg[CP_3S0_BIT]))
        else $error("PLL three set0 tuning wrong");
    a_pll3_high: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) && $past(set_active_q) |->
        pll3_filter_long_q == $past(cfg[LF_3S1_BIT]) &&
        pll3_pump_high_q == $past(cfg[CP_3S1_BIT]))
        else $error("PLL three set1 tuning wrong");
    a_tune_ab: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) |->
        pll1_filter_long_q == $past(cfg[LF_1_BIT]) &&
        pll2_filter_long_q == $past(cfg[LF_2_BIT]) &&
        pll1_pump_high_q == $past(cfg[CP_1_BIT]) &&
        pll2_pump_high_q == $past(cfg[CP_2_BIT]))
        else $error("PLL one or two tuning wrong");
    sequence s_pin_moved;
        sel_s_q != set_active_q;
    endsequence
    a_set_follow: assert property (@(posedge clk) disable iff (rst)
        s_pin_moved ##1 (sel_s_q == $past(sel_s_q)) |=>
        set_active_q == $past(sel_s_q, 2))
        else $error("set select not followed");
    a_set_held: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) && $changed(set_active_q) |->
        $past(state_q) == CMPD_SWAP)
        else $error("active set moved outside a swap");

endmodule // cmpd_clock_config
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import cmpd_pkg::*;
    logic                clk;
    logic                rst;
    logic [CFG_W-1:0]    cfg;
    logic                cd_set_select;
    logic [3:0]          src_tick;
    logic [3:0]          out_clk;
    cmpd_src_t           src_sel_a_q, src_sel_b_q, src_sel_c_q, src_sel_d_q;
    logic [DIV_W-1:0]    ratio_a_q, ratio_b_q, ratio_c_q, ratio_d_q;
    logic                pll1_filter_long_q, pll2_filter_long_q;
    logic                pll3_filter_long_q, pll1_pump_high_q;
    logic                pll2_pump_high_q, pll3_pump_high_q;
    logic                set_active_q;
    logic                a;
    int                  miscompares;
    int                  checks_done;
    logic [5:0]          rt [16] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05,
        6'h06, 6'h08, 6'h09, 6'h0a, 6'h0c, 6'h0f, 6'h10, 6'h12, 6'h14,
        6'h19, 6'h32};

    cmpd_clock_config dut_u (
        .clk, .rst, .cfg, .cd_set_select, .src_tick, .out_clk,
        .src_sel_a_q, .src_sel_b_q, .src_sel_c_q, .src_sel_d_q,
        .ratio_a_q, .ratio_b_q, .ratio_c_q, .ratio_d_q,
        .pll1_filter_long_q, .pll2_filter_long_q, .pll3_filter_long_q,
        .pll1_pump_high_q, .pll2_pump_high_q, .pll3_pump_high_q,
        .set_active_q
    );

    always #50 clk = ~clk;

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
            miscompares++;
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic do_reset;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #10;
        rst = 1'b0;
        check("ratios", {ratio_a_q, ratio_b_q, ratio_c_q, ratio_d_q},
              {4{6'h01}});
        check("sources", {src_sel_a_q, src_sel_b_q, src_sel_c_q,
              src_sel_d_q}, 8'h00);
        check("tuning", {pll1_filter_long_q, pll2_filter_long_q,
              pll3_filter_long_q, pll1_pump_high_q, pll2_pump_high_q,
              pll3_pump_high_q, set_active_q, out_clk}, 11'h000);
    endtask

    // Every code reaches every path field, and the unselected set always
    // differs from the selected one so a swapped set cannot pass.
    task automatic run_set(input logic sel);
        logic [3:0] kk;
        logic [1:0] s;
        for (int k = 0; k < 16; k++) begin
            kk = 4'(k);
            s = kk[1:0];
            cfg = '0;
            cfg[99:96] = kk;
            cfg[103:100] = ~kk;
            cfg[107:104] = kk + 4'h1;
            cfg[111:108] = kk + 4'h2;
            cfg[115:112] = kk + 4'h3;
            cfg[119:116] = kk + 4'h4;
            cfg[23:22] = s;
            cfg[47:46] = s + 2'h1;
            cfg[71:70] = s + 2'h2;
            cfg[95:94] = s + 2'h3;
            cfg[125:124] = s;
            cfg[127:126] = s + 2'h1;
            {cfg[20], cfg[44], cfg[68], cfg[92]} =
                {kk[0], kk[1], kk[2], !kk[2]};
            {cfg[19], cfg[43], cfg[67], cfg[91]} =
                {kk[1], kk[0], kk[3], !kk[3]};
            repeat (2) @(posedge clk);
            #10;
            check("ratio_a", ratio_a_q, rt[kk]);
            check("ratio_b", ratio_b_q, rt[~kk]);
            check("ratio_c", ratio_c_q,
                  sel ? rt[kk+4'h3] : rt[kk+4'h1]);
            check("ratio_d", ratio_d_q,
                  sel ? rt[kk+4'h4] : rt[kk+4'h2]);
            check("src_a", src_sel_a_q, s);
            check("src_b", src_sel_b_q, 2'(s + 2'h1));
            check("src_c", src_sel_c_q, 2'(sel ? s : s + 2'h2));
            check("src_d", src_sel_d_q, 2'(sel ? s + 2'h1 : s + 2'h3));
            check("filter", {pll1_filter_long_q, pll2_filter_long_q,
                  pll3_filter_long_q},
                  {kk[0], kk[1], sel ? !kk[2] : kk[2]});
            check("pump", {pll1_pump_high_q, pll2_pump_high_q,
                  pll3_pump_high_q},
                  {kk[1], kk[0], sel ? !kk[3] : kk[3]});
        end
    endtask

    // The first toggle may be stretched by the config change, so only the
    // second interval is timed.
    task automatic meas(input int p, input logic [7:0] exp);
        logic v;
        int   n;
        n = 0;
        @(posedge clk);
        #1;
        v = out_clk[p];
        while (out_clk[p] === v && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        v = out_clk[p];
        n = 0;
        while (out_clk[p] === v && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("half_period", 8'(n), exp);
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        cfg = '0;
        cd_set_select = 1'b0;
        src_tick = 4'h0;
        miscompares = 0;
        checks_done = 0;
        do_reset;
        $display("test reset done");
        run_set(1'b0);
        $display("test set0 decode done");
        cd_set_select = 1'b1;
        repeat (2) @(posedge clk);
        #10;
        check("set_early", set_active_q, 1'b0);
        repeat (4) @(posedge clk);
        #10;
        check("set_late", set_active_q, 1'b1);
        run_set(1'b1);
        $display("test set1 decode done");
        cfg = '0;
        cfg[23:22] = 2'h2;
        cfg[99:96] = 4'h2;
        cfg[125:124] = 2'h1;
        cfg[115:112] = 4'hf;
        cfg[127:126] = 2'h3;
        cfg[119:116] = 4'h6;
        src_tick = 4'hf;
        meas(0, 8'h03);
        meas(1, 8'h01);
        meas(2, 8'h32);
        meas(3, 8'h08);
        #9;
        src_tick = 4'hb;
        repeat (2) @(posedge clk);
        #10;
        a = out_clk[0];
        repeat (20) @(posedge clk);
        #10;
        check("stall_a", out_clk[0], a);
        cd_set_select = 1'b0;
        repeat (8) @(posedge clk);
        #10;
        check("swap_back", {set_active_q, src_sel_c_q, ratio_c_q},
              {1'b0, 2'h0, 6'h01});
        $display("test output clocks done");
        do_reset;
        $display("test second reset done");
        stop_test;
    end

    // The whole sequence needs well under 2000 cycles; this is ten times
    // that, so only a hang can reach it.
    initial begin
        #2_000_000;
        miscompares++;
        stop_test;
    end
endmodule // tb
`default_nettype wire
